// ==== hw/ddl_pkg.sv ====
// Shared constants and carrier types for the double-buffered DAC load control.
package ddl_pkg;

    // Width of the converter word held in both latches.
    localparam int DATA_W = 14;
    // Number of serial clock falling edges that make one frame.
    localparam int FRAME_BITS = 16;
    // Width of the serial bit counter.
    localparam int CNT_W = 5;
    // Bit count value that marks a complete frame.
    localparam logic [4:0] FRAME_LAST = 5'h10;
    // Depth of the word FIFO between the link and the core.
    localparam int FIFO_DEPTH = 4;
    // Value of both latches after reset.
    localparam logic [13:0] LATCH_RESET = 14'h0000;
    // Value of the bit counter after reset.
    localparam logic [4:0] CNT_RESET = 5'h00;

    // A word handed from the serial link to the core domain.
    typedef struct packed {
        logic [13:0] word;  // Aligned 14-bit converter code.
        logic        load;  // Load strobe was low at the sixteenth falling edge of the frame.
    } ddl_frame_type;

    // Parallel bus pins after synchronisation.
    typedef struct packed {
        logic        cs_n;  // Chip select, active low.
        logic        wr_n;  // Write strobe, active low.
        logic [13:0] data;  // Parallel data word.
    } ddl_par_type;

endpackage

// ==== hw/ddl_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module ddl_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
    logic [AW-1:0]    wr_ptr;       // Next slot to fill.
    logic [AW-1:0]    rd_ptr;       // Oldest slot.
    logic [AW:0]      count;        // Words held.
    logic             push;         // Accepted write.
    logic             pop;          // Accepted read.

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;

    // Storage carries no reset; only pointers and count need a defined value.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointer and count bookkeeping.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== hw/ddl_load_ctrl.sv ====
// Double-buffered DAC load control with parallel and serial input paths.
`timescale 1ns/1ns
module ddl_load_ctrl
    import ddl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        serial_mode,
    input  wire logic        cs_n,
    input  wire logic        wr_n,
    input  wire logic [13:0] par_data,
    input  wire logic        output_load_strobe_n,
    input  wire logic        serial_clk,
    input  wire logic        frame_sync_n,
    input  wire logic        serial_data_in,
    input  wire logic        bit_order_select,
    input  wire logic        frame_alignment_select,
    output logic      [13:0] input_latch,
    output logic      [13:0] dac_latch,
    output logic             dac_update,
    output logic             frame_overrun
);
    // ---------------- Serial link domain ----------------
    logic [15:0]    shift;          // Bits received so far, first bit at the top.
    logic [CNT_W-1:0] bit_cnt;      // Falling edges counted in this frame.
    logic           load_held;      // Strobe low at the last falling edge.
    logic           frame_tgl;      // Toggles once per completed frame.
    logic [13:0]    frame_word;     // Aligned word of the last frame.
    logic           frame_load;     // Load decision of the last frame.
    logic [15:0]    next_shift;
    logic [CNT_W-1:0] next_bit_cnt;
    logic           next_load_held;
    logic           next_frame_tgl;
    logic [13:0]    next_frame_word;
    logic           next_frame_load;
    logic [15:0]    full_frame;     // Frame including the bit on this edge.

    // Pick 14 of 16 bits; the order select reverses, alignment drops first or last two.
    function automatic logic [13:0] align_word(input logic [15:0] f, input logic msb_first,
                                               input logic pad_last);
        logic [13:0] raw;
        logic [13:0] rev;
        raw = pad_last ? f[15:2] : f[13:0];
        for (int i = 0; i < DATA_W; i++) begin
            rev[i] = raw[DATA_W-1-i];
        end
        return msb_first ? raw : rev;
    endfunction

    // Next-state logic for the shifter; the link clock may stop between frames.
    always_comb begin
        full_frame      = {shift[14:0], serial_data_in};
        next_shift      = shift;
        next_bit_cnt    = bit_cnt;
        next_load_held  = load_held;
        next_frame_tgl  = frame_tgl;
        next_frame_word = frame_word;
        next_frame_load = frame_load;
        if (!frame_sync_n && serial_mode) begin
            next_shift   = full_frame;
            next_bit_cnt = (bit_cnt == CNT_RESET) ? CNT_W'(1) : bit_cnt + 1'b1;
            // The strobe level at the closing edge decides; a strobe that fell
            // mid-frame and stayed low loads, one that rose again before the end does not.
            next_load_held = !output_load_strobe_n;
            if (next_bit_cnt == FRAME_LAST) begin
                next_frame_word = align_word(full_frame, bit_order_select,
                                             frame_alignment_select);
                next_frame_load = next_load_held;
                next_frame_tgl  = !frame_tgl;
                next_bit_cnt    = CNT_RESET;
            end
        end else begin
            next_bit_cnt = CNT_RESET;
        end
    end

    // Serial registers on the falling link clock edge.
    always_ff @(negedge serial_clk or posedge rst) begin
        if (rst) begin
            shift      <= '0;
            bit_cnt    <= CNT_RESET;
            load_held  <= 1'b0;
            frame_tgl  <= 1'b0;
            frame_word <= LATCH_RESET;
            frame_load <= 1'b0;
        end else begin
            shift      <= next_shift;
            bit_cnt    <= next_bit_cnt;
            load_held  <= next_load_held;
            frame_tgl  <= next_frame_tgl;
            frame_word <= next_frame_word;
            frame_load <= next_frame_load;
        end
    end

    // In-frame flag for the core, as a level crossing.
    logic in_frame;
    assign in_frame = (bit_cnt != CNT_RESET);

    // ---------------- Core domain: input synchronisers ----------------
    logic [2:0] tgl_s, act_s, ld_s, cs_s, wr_s, mode_s;
    logic [13:0] d_s1, d_s2;       // Parallel data, two stages, sampled every enabled cycle.
    logic frame_seen;               // Last toggle value taken from the link.
    logic ld_prev;                  // Agreed load strobe level.
    logic cs_prev, wr_prev, mode_q; // Agreed control levels.

    // Three-stage synchronisers for controls, two stages for data; the first stage feeds only the second.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tgl_s  <= '0;
            act_s  <= '0;
            ld_s   <= 3'h7;
            cs_s   <= 3'h7;
            wr_s   <= 3'h7;
            mode_s <= '0;
            d_s1   <= LATCH_RESET;
            d_s2   <= LATCH_RESET;
        end else if (clk_en) begin
            tgl_s  <= {tgl_s[1:0], frame_tgl};
            act_s  <= {act_s[1:0], in_frame};
            ld_s   <= {ld_s[1:0], output_load_strobe_n};
            cs_s   <= {cs_s[1:0], cs_n};
            wr_s   <= {wr_s[1:0], wr_n};
            mode_s <= {mode_s[1:0], serial_mode};
            d_s1   <= par_data;
            d_s2   <= d_s1;
        end
    end

    // A level counts as changed only once stages two and three agree; act_lvl takes stage three alone.
    logic ld_lvl, cs_lvl, wr_lvl, mode_lvl, act_lvl;
    assign ld_lvl   = (ld_s[1] == ld_s[2]) ? ld_s[2] : ld_prev;
    assign cs_lvl   = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_prev;
    assign wr_lvl   = (wr_s[1] == wr_s[2]) ? wr_s[2] : wr_prev;
    assign mode_lvl = (mode_s[1] == mode_s[2]) ? mode_s[2] : mode_q;
    assign act_lvl  = act_s[2];

    // ---------------- Frame FIFO ----------------
    ddl_frame_type fifo_in, fifo_out;
    logic          fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic          frame_new;
    assign frame_new     = (tgl_s[2] == tgl_s[1]) && (tgl_s[2] != frame_seen);
    assign fifo_in       = '{word: frame_word, load: frame_load};
    assign fifo_in_valid = frame_new;

    ddl_fifo #(.WIDTH($bits(ddl_frame_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1)
    );

    // ---------------- Core domain: latches ----------------
    ddl_par_type par;
    logic [13:0] next_input_latch, next_dac_latch;
    logic        next_dac_update, next_overrun, next_frame_seen;
    logic        in_transp;        // Input latch passing data this cycle.
    assign par = '{cs_n: cs_lvl, wr_n: wr_lvl, data: d_s2};

    // Latch control; in parallel mode the input and DAC paths never pass data in one cycle.
    always_comb begin
        next_input_latch = input_latch;
        next_dac_latch   = dac_latch;
        next_dac_update  = 1'b0;
        next_overrun     = frame_overrun;
        next_frame_seen  = frame_seen;
        in_transp        = !mode_lvl && !par.cs_n && !par.wr_n;
        if (in_transp) begin
            next_input_latch = par.data;
        end
        if (frame_new) begin
            next_frame_seen = tgl_s[2];
            next_overrun    = !fifo_in_ready;  // Set when a frame is lost, cleared by the next accepted frame.
        end
        if (fifo_out_valid && mode_lvl) begin
            next_input_latch = fifo_out.word;
            if (fifo_out.load) begin
                next_dac_latch  = fifo_out.word;
                next_dac_update = 1'b1;
            end
        end else if (!in_transp && !ld_lvl && !(mode_lvl && act_lvl)
                     && (ld_prev || !mode_lvl)) begin
            // Falling edge loads; a held-low strobe in parallel mode keeps it transparent.
            next_dac_latch  = next_input_latch;
            next_dac_update = (next_dac_latch != dac_latch) || ld_prev;
        end
        if (frame_new && !fifo_in_ready) begin
            next_overrun = 1'b1;
        end
    end

    // Register stage for the latches and edge history.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            input_latch   <= LATCH_RESET;
            dac_latch     <= LATCH_RESET;
            dac_update    <= 1'b0;
            frame_overrun <= 1'b0;
            frame_seen    <= 1'b0;
            ld_prev       <= 1'b1;
            cs_prev       <= 1'b1;
            wr_prev       <= 1'b1;
            mode_q        <= 1'b0;
        end else if (clk_en) begin
            input_latch   <= next_input_latch;
            dac_latch     <= next_dac_latch;
            dac_update    <= next_dac_update;
            frame_overrun <= next_overrun;
            frame_seen    <= next_frame_seen;
            ld_prev       <= ld_lvl;
            cs_prev       <= cs_lvl;
            wr_prev       <= wr_lvl;
            mode_q        <= mode_lvl;
        end
    end

    // ---------------- Checks ----------------
    AST_NO_BOTH: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && in_transp) |=> !dac_update || mode_q)
        else $error("DAC latch loaded while input latch transparent");
    AST_FALL_LOAD: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && !mode_lvl && !in_transp && ld_prev && !ld_lvl) |=> dac_latch == input_latch)
        else $error("Load strobe fall did not copy input latch");
    AST_PAR_CAPT: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && in_transp) |=> input_latch == $past(d_s2))
        else $error("Parallel data not passed while transparent");
    AST_MIDFRAME: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && mode_lvl && act_lvl && !fifo_out_valid) |=> $stable(dac_latch))
        else $error("DAC latch changed by strobe during a frame");
    AST_SER_LOAD: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && mode_lvl && fifo_out_valid && fifo_out.load) |=> dac_update)
        else $error("Completed held frame did not update DAC latch");
    AST_NO_LOAD: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && mode_lvl && fifo_out_valid && !fifo_out.load) |=> $stable(dac_latch))
        else $error("Cancelled frame changed DAC latch");
    AST_CNT16: assert property (@(negedge serial_clk) disable iff (rst)
        bit_cnt <= FRAME_LAST - 1'b1)
        else $error("Bit count passed sixteen");
    AST_ALIGN: assert property (@(negedge serial_clk) disable iff (rst)
        (!frame_sync_n && serial_mode && bit_cnt == FRAME_LAST - 1'b1) |=>
        frame_word == align_word($past(full_frame), $past(bit_order_select),
                                 $past(frame_alignment_select)))
        else $error("Frame word misaligned");
    COV_PAR: cover property (@(posedge core_clk) disable iff (rst) in_transp ##1 !in_transp);
    COV_SER: cover property (@(posedge core_clk) disable iff (rst) fifo_out_valid && fifo_out.load);
    COV_CANCEL: cover property (@(posedge core_clk) disable iff (rst)
        fifo_out_valid && !fifo_out.load);
endmodule

// ==== sim/ddl_host_model.sv ====
// Host model that sends serial frames to the load control on its own link clock.
`timescale 1ns/1ns
module ddl_host_model (
    output logic serial_clk,
    output logic frame_sync_n,
    output logic serial_data_in
);
    // The link clock is gated by the host, so it rests high between frames.
    initial begin
        serial_clk     = 1'b1;
        frame_sync_n   = 1'b1;
        serial_data_in = 1'b0;
    end
    // Sends bit 0 first; each bit is set half a period before its falling edge.
    task automatic send(input logic [15:0] s);
        #7 frame_sync_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            serial_data_in = s[i];
            #15 serial_clk = 1'b0;
            #15 serial_clk = 1'b1;
        end
        frame_sync_n   = 1'b1;
        // A released line must not keep showing a plausible last bit.
        serial_data_in = ~serial_data_in;
    endtask
endmodule

// ==== sim/dac_double_buffer_load_control_tb_top.sv ====
// Self-checking bench for the double-buffered DAC load control.
`timescale 1ns/1ns
module dac_double_buffer_load_control_tb_top;
    import ddl_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        clk_en;
    logic        serial_mode;
    logic        cs_n;
    logic        wr_n;
    logic [13:0] par_data;
    logic        output_load_strobe_n;
    logic        serial_clk;
    logic        frame_sync_n;
    logic        serial_data_in;
    logic        bit_order_select;
    logic        frame_alignment_select;
    logic [13:0] input_latch;
    logic [13:0] dac_latch;
    logic        dac_update;
    logic        frame_overrun;
    int          n_fail = 0;   // Mismatches seen.
    int          n_tests = 0;  // Comparisons made.
    int          n_upd = 0;    // Update pulses seen.
    int          e_upd = 0;    // Update pulses expected.
    int          seed;         // Random seed.
    logic [13:0] e_in;         // Model of the input latch.
    logic [13:0] e_dac;        // Model of the DAC latch.

    ddl_load_ctrl i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .serial_mode(serial_mode), .cs_n(cs_n), .wr_n(wr_n), .par_data(par_data),
        .output_load_strobe_n(output_load_strobe_n), .serial_clk(serial_clk),
        .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
        .bit_order_select(bit_order_select),
        .frame_alignment_select(frame_alignment_select), .input_latch(input_latch),
        .dac_latch(dac_latch), .dac_update(dac_update), .frame_overrun(frame_overrun));
    ddl_host_model i_host (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in));

    // Core clock at 100 MHz.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Counts update pulses; each one stands for exactly one cycle.
    always @(posedge core_clk) begin
        if (dac_update === 1'b1) begin
            n_upd <= n_upd + 1;
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Compares one value with its expectation.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Compares both latches and the update pulse count with the model.
    task automatic chk_all();
        chk({2'h0, input_latch}, {2'h0, e_in});
        chk({2'h0, dac_latch}, {2'h0, e_dac});
        chk(16'(n_upd), 16'(e_upd));
    endtask
    // Parallel write; data changes while the input latch is open.
    task automatic par_wr(input logic [13:0] d);
        par_data = ~d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        cyc(4);
        par_data = d;
        cyc(5);
        cs_n = 1'b1;
        wr_n = 1'b1;
        cyc(12);
        e_in = d;
    endtask
    // Load strobe pulse, kept apart from the chip select.
    task automatic load();
        output_load_strobe_n = 1'b0;
        cyc(4);
        output_load_strobe_n = 1'b1;
        cyc(6);
        e_dac = e_in;
        e_upd++;
    endtask
    // One frame; the strobe may fall lo and rise hi core cycles into it.
    task automatic ser(input logic [13:0] d, input int lo, input int hi, input logic ld);
        logic [15:0] s;
        s = 16'($random(seed));
        for (int k = 0; k < 14; k++)
            s[frame_alignment_select ? k : k + 2] = d[bit_order_select ? 13 - k : k];
        fork
            i_host.send(s);
            if (lo >= 0) begin
                cyc(lo);
                output_load_strobe_n = 1'b0;
                cyc(8);
                chk({2'h0, dac_latch}, {2'h0, e_dac});
                if (hi >= 0) begin
                    cyc(hi - lo - 8);
                    output_load_strobe_n = 1'b1;
                end
            end
        join
        cyc(12);
        e_in = d;
        if (ld) begin
            e_dac = d;
            e_upd++;
        end
    endtask

    // Cuts a hang short.
    initial begin
        #900000;
        n_fail++;
        wrap_up();
    end
    // Main sequence, driven at falling clock edges.
    initial begin
        seed = 32'h8e3e4101;
        rst = 1'b1;
        clk_en = 1'b1;
        serial_mode = 1'b0;
        cs_n = 1'b1;
        wr_n = 1'b1;
        par_data = 14'h0000;
        output_load_strobe_n = 1'b1;
        bit_order_select = 1'b0;
        frame_alignment_select = 1'b0;
        e_in = LATCH_RESET;
        e_dac = LATCH_RESET;
        cyc(20);
        rst = 1'b0;
        cyc(5);
        chk_all();
        chk({15'h0, frame_overrun}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            par_wr(14'($random(seed)));
            chk_all();
            load();
            chk_all();
        end
        serial_mode = 1'b1;
        cyc(5);
        // Every bit order and alignment, strobe high during the frame.
        for (int m = 0; m < 4; m++) begin
            {bit_order_select, frame_alignment_select} = 2'(m);
            cyc(3);
            ser(14'($random(seed)), -1, -1, 1'b0);
            chk_all();
            load();
            chk_all();
        end
        // Strobe low before the frame: the sixteenth edge loads the DAC.
        output_load_strobe_n = 1'b0;
        cyc(8);
        e_upd++;
        ser(14'($random(seed)), -1, -1, 1'b1);
        chk_all();
        output_load_strobe_n = 1'b1;
        cyc(6);
        ser(14'($random(seed)), 20, -1, 1'b1);
        chk_all();
        output_load_strobe_n = 1'b1;
        cyc(6);
        ser(14'($random(seed)), 20, 38, 1'b0);
        chk_all();
        // Core frozen: its synchronisers freeze too, so only the net toggle is seen
        // after the thaw and nothing is lost to the FIFO.
        clk_en = 1'b0;
        for (int i = 0; i < 7; i++) begin
            ser(14'($random(seed)), -1, -1, 1'b0);
        end
        clk_en = 1'b1;
        cyc(40);
        chk({15'h0, frame_overrun}, 16'h0000);
        ser(14'($random(seed)), -1, -1, 1'b0);
        chk_all();
        // Strobe held low in parallel mode: DAC holds while the input latch is open.
        serial_mode = 1'b0;
        output_load_strobe_n = 1'b0;
        cyc(8);
        par_data = 14'($random(seed));
        cs_n = 1'b0;
        wr_n = 1'b0;
        cyc(8);
        chk({2'h0, dac_latch}, {2'h0, e_in});
        cs_n = 1'b1;
        wr_n = 1'b1;
        cyc(12);
        chk({2'h0, dac_latch}, {2'h0, par_data});
        wrap_up();
    end
endmodule
